/* include/regfile_pkg.sv */
// Purpose: Shared constants and carrier types for the working register file
// Assumes: 8-bit register space of 256 bytes, one core clock
// Notes:   Operation codes are local to this block and its decode partner
package regfile_pkg;

  // ---------------------------------------------------------------
  // Address map and field layout
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          SHORT_W         = 4;
  localparam logic [7:0]  GROUP_PTR_ADDR  = 8'hFD;
  localparam logic [7:0]  GROUP_PTR_RESET = 8'h00;
  localparam logic [3:0]  GROUP_LOW_ZERO  = 4'h0;
  localparam logic [7:0]  STACK_PTR_ADDR  = 8'hFF;
  localparam logic [7:0]  FLAGS_ADDR      = 8'hFC;
  localparam logic [7:0]  STACK_RESET     = 8'h80;

  // ---------------------------------------------------------------
  // Instruction length and timing figures
  // ---------------------------------------------------------------
  localparam logic [1:0]  LEN_SET_GROUP   = 2'h2;
  localparam logic [3:0]  CYC_SET_GROUP   = 4'h6;
  localparam logic [1:0]  LEN_LOAD_LONG   = 2'h3;
  localparam logic [1:0]  LEN_LOAD_SHORT  = 2'h2;
  localparam logic [3:0]  CYC_LOAD_GROUP  = 4'hA;

  // ---------------------------------------------------------------
  // Operations issued by the decode unit
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_READ       = 3'h1,
    OP_LOAD       = 3'h2,
    OP_SET_GROUP  = 3'h3,
    OP_PAIR_INC   = 3'h4,
    OP_PAIR_DEC   = 3'h5,
    OP_DEC_BRANCH = 3'h6,
    OP_INT_STACK  = 3'h7
  } reg_op_t;

  // Operand addressing: long 8-bit, short 4-bit working, indirect
  typedef enum logic [1:0] {
    AM_LONG     = 2'h0,
    AM_SHORT    = 2'h1,
    AM_INDIRECT = 2'h2
  } addr_mode_t;

  typedef struct packed {
    reg_op_t    op;
    addr_mode_t mode;
    logic [7:0] operand;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  flags;
  } int_ctx_t;

endpackage : regfile_pkg

/* sim/decode_model.sv */
// Purpose: Decode-unit stand-in that issues register requests to the file
// Assumes: One request at a time, driven just after clk_sys rises
// Notes:   Idle request fields are inverted so a stale value never looks valid
`timescale 1ns/10ps
module decode_model (
  input  wire logic              clk_sys,
  output logic                   req_valid,
  output regfile_pkg::reg_req_t  req,
  output regfile_pkg::int_ctx_t  int_ctx
);
  // Quiet bus before the first request
  initial begin
    req_valid = 1'b0;
    req       = '0;
    int_ctx   = '0;
  end

  // ---------------------------------------------------------------
  // Request issue
  // ---------------------------------------------------------------
  // Direct pair operands name the even register; an indirect pair pointer may hold an odd one
  // Decrement-and-branch goes to working registers only
  // Control registers see plain loads and set-group, plus the stack pointer decrement of interrupt stacking
  task automatic issue(input regfile_pkg::reg_op_t    op,
                       input regfile_pkg::addr_mode_t mode,
                       input logic [7:0]              operand,
                       input logic [7:0]              wdata);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req       <= '{op, mode, operand, wdata};
    @(posedge clk_sys);  // Request taken at this edge
    req_valid <= 1'b0;
    req       <= regfile_pkg::reg_req_t'(~req);
  endtask : issue

  // Interrupt cycle: context stands with the request
  task automatic stack(input logic [15:0] pc, input logic [7:0] flags);
    int_ctx <= '{pc, flags};
    issue(regfile_pkg::OP_INT_STACK, regfile_pkg::AM_LONG, 8'h00, 8'h00);
  endtask : stack
endmodule : decode_model

/* sim/working_register_file_tb_top.sv */
// Purpose: Self-checking bench for the working register file
// Assumes: Responses settle at the taking edge and are checked 1 ns after it
// Notes:   Stack pointer is loaded before interrupt stacking, as reset leaves it open
`timescale 1ns/10ps
module working_register_file_tb_top;
  logic                  clk_sys;
  logic                  rst;
  logic                  req_valid;
  regfile_pkg::reg_req_t req;
  regfile_pkg::int_ctx_t int_ctx;
  logic                  rsp_valid;
  logic            [7:0] rsp_data;
  logic                  branch_taken;
  logic            [7:0] group_ptr;
  logic            [1:0] instr_len;
  logic            [3:0] instr_cycles;
  int                    miscompares = 0;
  int                    n_checks    = 0;

  decode_model i_decode_model (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
                               .int_ctx(int_ctx));
  working_register_file i_working_register_file (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .int_ctx(int_ctx),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .branch_taken(branch_taken),
    .group_ptr(group_ptr), .instr_len(instr_len), .instr_cycles(instr_cycles));

  // 25 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // Issue then step past the taking edge so registered answers have landed
  task automatic op(input regfile_pkg::reg_op_t o, input regfile_pkg::addr_mode_t m,
                    input logic [7:0] a, input logic [7:0] d);
    i_decode_model.issue(o, m, a, d);
    #1;
  endtask : op

  task automatic ld(input logic [7:0] a, input logic [7:0] d);
    op(regfile_pkg::OP_LOAD, regfile_pkg::AM_LONG, a, d);
  endtask : ld

  task automatic rd(input regfile_pkg::addr_mode_t m, input logic [7:0] a,
                    input logic [7:0] exp);
    op(regfile_pkg::OP_READ, m, a, 8'h00);
    chk8({7'h00, rsp_valid}, 8'h01);
    chk8(rsp_data, exp);
  endtask : rd

  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_long();
    logic [7:0] addrs [4] = '{8'h00, 8'h5A, 8'hF0, 8'hFE};
    foreach (addrs[i]) begin
      ld(addrs[i], addrs[i] ^ 8'h3C);
      chk8({6'h00, instr_len}, 8'h03);
      rd(regfile_pkg::AM_LONG, addrs[i], addrs[i] ^ 8'h3C);
    end
  endtask : t_long

  // Set-group forces the low nibble; a plain load copies all bits
  task automatic t_group();
    op(regfile_pkg::OP_SET_GROUP, regfile_pkg::AM_LONG, 8'h00, 8'h47);
    chk8(group_ptr, 8'h40);
    chk8({6'h00, instr_len}, 8'h02);
    chk8({4'h0, instr_cycles}, 8'h06);
    ld(8'hFD, 8'h73);
    chk8(group_ptr, 8'h73);
    chk8({4'h0, instr_cycles}, 8'h0A);
    rd(regfile_pkg::AM_LONG, 8'hFD, 8'h73);
  endtask : t_group

  task automatic t_short();
    op(regfile_pkg::OP_SET_GROUP, regfile_pkg::AM_LONG, 8'h00, 8'h7F);
    chk8(group_ptr, 8'h70);
    op(regfile_pkg::OP_LOAD, regfile_pkg::AM_SHORT, 8'h06, 8'h01);
    chk8({6'h00, instr_len}, 8'h02);
    rd(regfile_pkg::AM_LONG, 8'h76, 8'h01);
    rd(regfile_pkg::AM_SHORT, 8'h06, 8'h01);
  endtask : t_short

  // Carry and borrow must cross from low to high byte
  task automatic t_pair();
    ld(8'h7E, 8'h12);
    ld(8'h7F, 8'hFF);
    op(regfile_pkg::OP_PAIR_INC, regfile_pkg::AM_LONG, 8'h7E, 8'h00);
    rd(regfile_pkg::AM_LONG, 8'h7E, 8'h13);
    rd(regfile_pkg::AM_LONG, 8'h7F, 8'h00);
    op(regfile_pkg::OP_PAIR_DEC, regfile_pkg::AM_LONG, 8'h7E, 8'h00);
    rd(regfile_pkg::AM_LONG, 8'h7E, 8'h12);
    rd(regfile_pkg::AM_LONG, 8'h7F, 8'hFF);
    op(regfile_pkg::OP_PAIR_INC, regfile_pkg::AM_SHORT, 8'h0E, 8'h00);
    rd(regfile_pkg::AM_LONG, 8'h7E, 8'h13);
    rd(regfile_pkg::AM_LONG, 8'h7F, 8'h00);
    ld(8'h30, 8'h51);
    ld(8'h50, 8'h20);
    ld(8'h51, 8'hFF);
    op(regfile_pkg::OP_PAIR_INC, regfile_pkg::AM_INDIRECT, 8'h30, 8'h00);
    rd(regfile_pkg::AM_LONG, 8'h50, 8'h21);
    rd(regfile_pkg::AM_LONG, 8'h51, 8'h00);
  endtask : t_pair

  task automatic t_decrement_branch_nonzero_op();
    op(regfile_pkg::OP_LOAD, regfile_pkg::AM_SHORT, 8'h01, 8'h02);
    op(regfile_pkg::OP_DEC_BRANCH, regfile_pkg::AM_SHORT, 8'h01, 8'h00);
    chk8({6'h00, rsp_valid, branch_taken}, 8'h03);
    chk8(rsp_data, 8'h01);
    op(regfile_pkg::OP_DEC_BRANCH, regfile_pkg::AM_SHORT, 8'h01, 8'h00);
    chk8({6'h00, rsp_valid, branch_taken}, 8'h02);
    chk8(rsp_data, 8'h00);
    chk8({2'h0, instr_len, instr_cycles}, 8'h00);
  endtask : t_decrement_branch_nonzero_op

  // Only program counter and flags are pushed; a general register stays put
  task automatic t_stack();
    ld(8'hFF, 8'h90);
    ld(8'h41, 8'h5C);
    i_decode_model.stack(16'h1234, 8'hA5);
    rd(regfile_pkg::AM_LONG, 8'h8F, 8'h34);
    rd(regfile_pkg::AM_LONG, 8'h8E, 8'h12);
    rd(regfile_pkg::AM_LONG, 8'h8D, 8'hA5);
    rd(regfile_pkg::AM_LONG, 8'hFF, 8'h8D);
    rd(regfile_pkg::AM_LONG, 8'h41, 8'h5C);
  endtask : t_stack

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk8(group_ptr, 8'h00);
    chk8({5'h00, rsp_valid, instr_len}, 8'h00);
    t_long();
    t_group();
    t_short();
    t_pair();
    t_decrement_branch_nonzero_op();
    t_stack();
    test_done();
  end

  // Whole run needs well under 200 cycles; the margin is generous
  initial begin
    #(40 * 4000);
    miscompares++;
    test_done();
  end
endmodule : working_register_file_tb_top

/* verilog/pair_incdec.sv */
// Purpose: 16-bit increment or decrement of a register pair
// Assumes: High byte is the even register
// Notes:   Carry or borrow ripples from low to high byte
`timescale 1ns/10ps
module pair_incdec (
  input  wire logic [7:0] hi_in,
  input  wire logic [7:0] lo_in,
  input  wire logic       decrement,
  output logic      [7:0] hi_out,
  output logic      [7:0] lo_out
);
  logic [15:0] word_out;

  // One 16-bit add keeps the carry chain between halves
  always_comb begin
    word_out = decrement ? ({hi_in, lo_in} - 16'h0001)
                         : ({hi_in, lo_in} + 16'h0001); // RULE13
    hi_out   = word_out[15:8];
    lo_out   = word_out[7:0];
  end
endmodule : pair_incdec

/* verilog/reg_addr_map.sv */
// Purpose: Forms physical register addresses from long or short operands
// Assumes: Group pointer low nibble is ignored; only bits 7:4 are used
// Notes:   Purely combinational
`timescale 1ns/10ps
module reg_addr_map (
  input  wire logic [7:0] operand,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] group_ptr,
  input  wire logic [7:0] indirect_val,
  input  wire logic       pair_ref,
  output logic      [7:0] phys_addr
);
  logic [7:0] raw_addr;

  // Long operand passes through; short joins with group high nibble
  always_comb begin
    unique case (mode)
      2'h1:    raw_addr = {group_ptr[7:4], operand[3:0]}; // RULE7 RULE15
      2'h2:    raw_addr = indirect_val;
      default: raw_addr = operand; // RULE6
    endcase
    // Pair references always land on the even register
    phys_addr = pair_ref ? {raw_addr[7:1], 1'b0} : raw_addr; // RULE14
  end
endmodule : reg_addr_map

/* verilog/working_register_file.sv */
// Purpose: Register file with long, short and pair addressing for an 8-bit core
// Assumes: Decode unit issues one request per cycle on req_valid
// Notes:   Reads return one cycle after the request; writes land at that same clock edge
`timescale 1ns/10ps

// Functional notes
// [RULE1] Pairs join an even register as high byte with the next register as low byte.
// [RULE2] The decode unit names a pair only by its even register; odd starts are invalid.
// [RULE3] Every 8-bit register, including control and status, is reachable by any operation; pair and decrement ops at FD leave group_ptr unchanged.
// [RULE4] Decrement-and-branch is meaningful only on general working registers.
// [RULE5] Write-only controls are changed only by load, pop or clear operations.
// [RULE6] A full 8-bit long address covers the whole range 00 to FF.
// [RULE7] A 4-bit short address picks one of 16 working registers in a 16-byte group.
// [RULE8] The active group comes from the group pointer register at FD.
// [RULE9] The set-group operation loads the upper nibble and forces the lower nibble to zero.
// [RULE10] Set-group is two bytes and six cycles; a general load to the pointer is three and ten.
// [RULE11] A long-address load is three bytes and a short-address load two bytes.
// [RULE12] An interrupt cycle pushes program counter and flags, not general registers.
// [RULE13] Pair increment and decrement carry from the low to the high register.
// [RULE14] An indirect pair reference forces the low address bit to even.
// [RULE15] The working address is the group high nibble joined with the short address.
module working_register_file (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 req_valid,
  input  wire regfile_pkg::reg_req_t req,
  input  wire regfile_pkg::int_ctx_t int_ctx,
  output logic                      rsp_valid,
  output logic                [7:0] rsp_data,
  output logic                      branch_taken,
  output logic                [7:0] group_ptr,
  output logic                [1:0] instr_len,
  output logic                [3:0] instr_cycles
);

  // ---------------------------------------------------------------
  // Storage and address decode
  // ---------------------------------------------------------------
  logic [7:0] mem [0:255];
  logic [7:0] phys_addr;
  logic [7:0] pair_lo_addr;
  logic [7:0] hi_new;
  logic [7:0] lo_new;
  logic [7:0] dec_val;
  logic [7:0] ptr_addr;
  logic [7:0] sp_now;
  logic       pair_ref;
  logic       int_phase;

  // Indirect pointer itself is addressed by the full 8-bit operand, never by short form
  assign ptr_addr = req.operand;
  assign pair_ref = (req.op == regfile_pkg::OP_PAIR_INC) ||
                    (req.op == regfile_pkg::OP_PAIR_DEC);

  reg_addr_map u_map (
    .operand      (req.operand),
    .mode         (req.mode),
    .group_ptr    (group_ptr),
    .indirect_val (mem[ptr_addr]),
    .pair_ref     (pair_ref),
    .phys_addr    (phys_addr)
  );

  assign pair_lo_addr = {phys_addr[7:1], 1'b1}; // RULE1

  pair_incdec u_pair (
    .hi_in     (mem[phys_addr]),
    .lo_in     (mem[pair_lo_addr]),
    .decrement (req.op == regfile_pkg::OP_PAIR_DEC),
    .hi_out    (hi_new),
    .lo_out    (lo_new)
  );

  assign dec_val = mem[phys_addr] - 8'h01;
  assign sp_now  = mem[regfile_pkg::STACK_PTR_ADDR];

  // ---------------------------------------------------------------
  // Register array writes
  // ---------------------------------------------------------------
  // Array has no reset; only the group pointer starts defined
  always_ff @(posedge clk_sys) begin
    if (req_valid) begin
      unique case (req.op)
        regfile_pkg::OP_LOAD: begin
          mem[phys_addr] <= req.wdata; // RULE3
        end
        regfile_pkg::OP_PAIR_INC, regfile_pkg::OP_PAIR_DEC: begin
          mem[phys_addr]    <= hi_new; // RULE13
          mem[pair_lo_addr] <= lo_new;
        end
        regfile_pkg::OP_DEC_BRANCH: begin
          mem[phys_addr] <= dec_val; // RULE4
        end
        regfile_pkg::OP_INT_STACK: begin
          // Push PC low, PC high, then flags; stack grows downward
          mem[sp_now - 8'h01]                 <= int_ctx.pc[7:0]; // RULE12
          mem[sp_now - 8'h02]                 <= int_ctx.pc[15:8];
          mem[sp_now - 8'h03]                 <= int_ctx.flags;
          mem[regfile_pkg::STACK_PTR_ADDR]    <= sp_now - 8'h03;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Group pointer register
  // ---------------------------------------------------------------
  // Held outside the array so its low nibble stays zero on set-group
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      group_ptr <= regfile_pkg::GROUP_PTR_RESET;
    end else if (req_valid && req.op == regfile_pkg::OP_SET_GROUP) begin
      group_ptr <= {req.wdata[7:4], regfile_pkg::GROUP_LOW_ZERO}; // RULE9
    end else if (req_valid && req.op == regfile_pkg::OP_LOAD &&
                 phys_addr == regfile_pkg::GROUP_PTR_ADDR) begin
      group_ptr <= req.wdata; // RULE8
    end
  end

  // Tracks interrupt entry for the stack assertion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_phase <= 1'b0;
    end else begin
      int_phase <= req_valid && req.op == regfile_pkg::OP_INT_STACK;
    end
  end

  // ---------------------------------------------------------------
  // Read path and instruction figures
  // ---------------------------------------------------------------
  // Pointer reads come from the dedicated flop, not the shadow array
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h00;
      branch_taken <= 1'b0;
    end else begin
      rsp_valid    <= req_valid && (req.op == regfile_pkg::OP_READ ||
                                    req.op == regfile_pkg::OP_DEC_BRANCH);
      branch_taken <= req_valid && req.op == regfile_pkg::OP_DEC_BRANCH &&
                      dec_val != 8'h00;
      if (req_valid && req.op == regfile_pkg::OP_READ) begin
        rsp_data <= (phys_addr == regfile_pkg::GROUP_PTR_ADDR) ? group_ptr
                                                               : mem[phys_addr];
      end else if (req_valid && req.op == regfile_pkg::OP_DEC_BRANCH) begin
        rsp_data <= dec_val;
      end
    end
  end

  // Length and cycle hints for the fetch unit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      instr_len    <= 2'h0;
      instr_cycles <= 4'h0;
    end else if (req_valid && req.op == regfile_pkg::OP_SET_GROUP) begin
      instr_len    <= regfile_pkg::LEN_SET_GROUP; // RULE10
      instr_cycles <= regfile_pkg::CYC_SET_GROUP;
    end else if (req_valid && req.op == regfile_pkg::OP_LOAD) begin
      instr_len    <= (req.mode == regfile_pkg::AM_SHORT) ? regfile_pkg::LEN_LOAD_SHORT
                                                          : regfile_pkg::LEN_LOAD_LONG; // RULE11
      instr_cycles <= (phys_addr == regfile_pkg::GROUP_PTR_ADDR) ?
                      regfile_pkg::CYC_LOAD_GROUP : 4'h0;
    end else if (req_valid) begin
      instr_len    <= 2'h0;
      instr_cycles <= 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_set_group_low_zero;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_SET_GROUP) |=>
        group_ptr == {$past(req.wdata[7:4]), 4'h0} && instr_cycles == 4'h6;
  endproperty
  a_set_group_low_zero: assert property (p_set_group_low_zero) // RULE9
    else $error("set group pointer wrong");

  property p_set_group_len;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_SET_GROUP) |=> instr_len == 2'h2;
  endproperty
  a_set_group_len: assert property (p_set_group_len) // RULE10
    else $error("set group length wrong");

  property p_load_len;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_LOAD) |=>
        instr_len == ($past(req.mode) == regfile_pkg::AM_SHORT ? 2'h2 : 2'h3);
  endproperty
  a_load_len: assert property (p_load_len) // RULE11
    else $error("load length wrong");

  // Idle request fields are scrambled, so every address check waits for req_valid
  property p_short_addr;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.mode == regfile_pkg::AM_SHORT && !pair_ref) |->
        phys_addr == {group_ptr[7:4], req.operand[3:0]};
  endproperty
  a_short_addr: assert property (p_short_addr) // RULE15
    else $error("short address wrong");

  property p_pair_even;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && pair_ref) |-> phys_addr[0] == 1'b0 && pair_lo_addr == phys_addr + 8'h01;
  endproperty
  a_pair_even: assert property (p_pair_even) // RULE14
    else $error("pair address odd");

  property p_pair_carry;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_PAIR_INC) |->
        {hi_new, lo_new} == {mem[phys_addr], mem[pair_lo_addr]} + 16'h0001;
  endproperty
  a_pair_carry: assert property (p_pair_carry) // RULE13
    else $error("pair carry wrong");

  property p_long_addr;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.mode == regfile_pkg::AM_LONG && !pair_ref) |->
        phys_addr == req.operand;
  endproperty
  a_long_addr: assert property (p_long_addr) // RULE6
    else $error("long address wrong");

  property p_int_stack;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_INT_STACK) |=>
        int_phase && sp_now == $past(sp_now) - 8'h03;
  endproperty
  a_int_stack: assert property (p_int_stack) // RULE12
    else $error("interrupt stack wrong");

  // Answers and stored values, judged one cycle after the taking edge; pair borrow is judged at the taking edge itself
  property p_read_answer;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_READ && phys_addr != 8'hFD) |=>
        rsp_valid && rsp_data == $past(mem[phys_addr]);
  endproperty
  a_read_answer: assert property (p_read_answer) // RULE3
    else $error("read data wrong");

  property p_read_pointer;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_READ && phys_addr == 8'hFD) |=>
        rsp_valid && rsp_data == $past(group_ptr);
  endproperty
  a_read_pointer: assert property (p_read_pointer) // RULE8
    else $error("pointer read wrong");

  property p_load_pointer;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_LOAD && phys_addr == 8'hFD) |=>
        group_ptr == $past(req.wdata) && instr_cycles == 4'hA;
  endproperty
  a_load_pointer: assert property (p_load_pointer) // RULE8
    else $error("pointer load wrong");

  property p_pointer_hold;
    @(posedge clk_sys) disable iff (rst)
      !(req_valid && (req.op == regfile_pkg::OP_SET_GROUP ||
                      (req.op == regfile_pkg::OP_LOAD && phys_addr == 8'hFD))) |=>
        group_ptr == $past(group_ptr);
  endproperty
  a_pointer_hold: assert property (p_pointer_hold) // RULE8
    else $error("pointer changed unasked");

  property p_load_write;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_LOAD) |=>
        mem[$past(phys_addr)] == $past(req.wdata);
  endproperty
  a_load_write: assert property (p_load_write) // RULE3
    else $error("load did not land");

  property p_dec_branch;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_DEC_BRANCH) |=>
        rsp_valid && (rsp_data == $past(mem[phys_addr]) - 8'h01) &&
        (branch_taken == (rsp_data != 8'h00));
  endproperty
  a_dec_branch: assert property (p_dec_branch) // RULE4
    else $error("decrement result wrong");

  property p_pair_borrow;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_PAIR_DEC) |->
        {hi_new, lo_new} == {mem[phys_addr], mem[pair_lo_addr]} - 16'h0001;
  endproperty
  a_pair_borrow: assert property (p_pair_borrow) // RULE13
    else $error("pair borrow wrong");

  property p_stack_push;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op == regfile_pkg::OP_INT_STACK) |=>
        mem[$past(sp_now) - 8'h01] == $past(int_ctx.pc[7:0]) &&
        mem[$past(sp_now) - 8'h02] == $past(int_ctx.pc[15:8]) &&
        mem[$past(sp_now) - 8'h03] == $past(int_ctx.flags);
  endproperty
  a_stack_push: assert property (p_stack_push) // RULE12
    else $error("context push wrong");

  property p_other_len;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req.op != regfile_pkg::OP_SET_GROUP &&
       req.op != regfile_pkg::OP_LOAD) |=>
        instr_len == 2'h0 && instr_cycles == 4'h0;
  endproperty
  a_other_len: assert property (p_other_len) // RULE11
    else $error("length hint not cleared");

endmodule : working_register_file
